/* core/liucfg_pkg.sv */
package liucfg_pkg;
    // Register offsets on the 8-bit host address
    localparam logic [7:0] ADDR_JITTER_CFG = 8'h01;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h20;
    localparam logic [7:0] ADDR_GLOBAL_CFG0 = 8'h40;
    localparam logic [7:0] ADDR_GLOBAL_CFG1 = 8'h60;
    localparam logic [7:0] ADDR_CH_IRQ_IND = 8'h80;
    // Channel number sits in address bits 7:6
    localparam int CH_SEL_MSB = 7;
    localparam int CH_SEL_LSB = 6;
    localparam int NUM_CH = 4;
    // Global config 0 fields
    localparam int GLOBAL_CONFIG_0_STD_BIT = 4;
    localparam int GLOBAL_CONFIG_0_COPY_BIT = 3;
    localparam int GLOBAL_CONFIG_0_MASK_BIT = 2;
    localparam int GLOBAL_CONFIG_0_PIN_MSB = 1;
    localparam int GLOBAL_CONFIG_0_PIN_LSB = 0;
    localparam logic [7:0] GLOBAL_CONFIG_0_RESET = 8'h04;
    localparam logic [7:0] GLOBAL_CONFIG_0_WMASK = 8'h3f;
    // Global config 1 fields
    localparam int GLOBAL_CONFIG_1_MON_LSB = 4;
    localparam logic [7:0] GLOBAL_CONFIG_1_RESET = 8'h00;
    localparam logic [7:0] GLOBAL_CONFIG_1_WMASK = 8'hf0;
    // Jitter config fields
    localparam int JITTER_WIDE_BW_LIMIT_BIT = 5;
    localparam int JA_PLACE_LSB = 3;
    localparam int JA_DEPTH_LSB = 1;
    localparam int JA_BW_BIT = 0;
    localparam logic [7:0] JACFG_RESET = 8'h00;
    localparam logic [7:0] JACFG_WMASK = 8'h3f;
    localparam logic [7:0] IND_RESET = 8'h00;

    typedef enum logic [1:0] {
        LIUCFG_JA_OFF = 2'h0,
        LIUCFG_JA_TX = 2'h1,
        LIUCFG_JA_RX = 2'h2
    } liucfg_ja_place_t;

    typedef enum logic [1:0] {
        LIUCFG_DEPTH_128 = 2'h0,
        LIUCFG_DEPTH_64 = 2'h1,
        LIUCFG_DEPTH_32 = 2'h2
    } liucfg_depth_t;

    // Decoded per-channel jitter settings
    typedef struct packed {
        liucfg_ja_place_t placement;
        liucfg_depth_t depth;
        logic wide_limit;
        logic low_corner;
    } liucfg_ja_t;

    // Decoded monitor routing
    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic [1:0] source_ch;
    } liucfg_mon_t;
endpackage : liucfg_pkg

/* core/liucfg_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - One global bit picks E1 (0) or T1/J1 (1) for all channels; resets E1.
// - With broadcast on, a channel register write lands in all four channels.
// - Global interrupt mask resets set; clearing it lets any pending channel drive the pin.
// - Pin style: x0 open-drain low, 01 push-pull low, 11 push-pull high.
// - Monitor codes 0010/0100/0110 route receiver 2/3/4 into channel 1.
// - Monitor codes 1010/1100/1110 pick transmitter 2/3/4; odd codes reserved.
// - Indication register sets bit 0/2/4/6 for channel 1-4; others zero.
// - Jitter placement: 00/10 off, 01 transmit path, 11 receive path.
// - Jitter depth: 00 is 128 bits, 01 is 64, 10/11 are 32.
// - Jitter bit 5 selects normal or widened-bandwidth limit mode; resets 0.
// - Corner bit picks high or low transfer corner, scaled per line standard.
// - Each channel owns a readable, writable jitter register at spaced addresses.
// - Any soft-reset write returns all registers but the pending synchroniser, and all outputs, to defaults.
module liucfg_regs
    import liucfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [NUM_CH-1:0] i_ch_irq_pending,
    output logic [7:0] o_rdata,
    output logic o_line_standard_select,
    output logic o_irq_out,
    output logic o_irq_oe,
    output liucfg_mon_t o_monitor,
    output liucfg_ja_t [NUM_CH-1:0] o_jitter
);

    // Address map seen by the host:
    //   0x01, 0x41, 0x81, 0xc1  per-channel jitter settings, channel in bits 7:6
    //   0x20                    soft reset, write only, reads back zero
    //   0x40                    global config 0: standard, broadcast, mask, pin style
    //   0x60                    global config 1: monitor routing in the top nibble
    //   0x80                    channel interrupt indication, read only
    // Anything else reads zero and ignores writes.
    // Every output is registered from next values, so settings show at the write edge itself.
    // Read data stands for one cycle only and is zero between reads.

    // Pending flags come from other channel logic, maybe another domain
    // Two stages keep metastability away from the indication and the pin;
    // the cost is two cycles of delay on every interrupt edge.
    logic [NUM_CH-1:0] pend_s1;
    logic [NUM_CH-1:0] pend_s2;
    logic [7:0] global_config_0;
    logic [7:0] global_config_1;
    logic [7:0] ind;
    logic [7:0] jacfg [NUM_CH];
    logic [7:0] next_global_config_0;
    logic [7:0] next_global_config_1;
    logic [7:0] next_ind;
    logic [7:0] next_jacfg [NUM_CH];
    logic [7:0] next_rdata;
    logic next_irq_out;
    logic next_irq_oe;
    liucfg_mon_t next_monitor;
    liucfg_ja_t [NUM_CH-1:0] next_jitter;
    logic soft_rst;
    logic irq_any;

    // Low address bits pick the register within a channel
    // Shared by write and read decode so the two cannot drift apart.
    function automatic logic hits(input logic [7:0] a, input logic [7:0] base);
        return a[CH_SEL_LSB-1:0] == base[CH_SEL_LSB-1:0];
    endfunction : hits

    // Folds duplicate codes onto one setting so users of the struct
    // never need to know which raw patterns alias each other.
    function automatic liucfg_ja_t decode_ja(input logic [7:0] r);
        liucfg_ja_t d;
        d.wide_limit = r[JITTER_WIDE_BW_LIMIT_BIT];
        d.low_corner = r[JA_BW_BIT];
        case (r[JA_PLACE_LSB +: 2])
            2'h1: d.placement = LIUCFG_JA_TX;
            2'h3: d.placement = LIUCFG_JA_RX;
            default: d.placement = LIUCFG_JA_OFF;
        endcase
        case (r[JA_DEPTH_LSB +: 2])
            2'h0: d.depth = LIUCFG_DEPTH_128;
            2'h1: d.depth = LIUCFG_DEPTH_64;
            default: d.depth = LIUCFG_DEPTH_32;
        endcase
        return d;
    endfunction : decode_ja

    // Soft reset is a one-cycle strobe; the written value is dropped.
    // It does not touch the pending synchroniser, which tracks live inputs.
    assign soft_rst = i_wr_en && (i_addr == ADDR_SOFT_RESET);

    // Global registers and indication
    // Config 0 keeps bit 5 as written; the host owns keeping it clear.
    // Bits 7:6 of config 0 and 3:0 of config 1 are masked so they always read back zero.
    always_comb begin
        next_global_config_0 = global_config_0;
        next_global_config_1 = global_config_1;
        if (i_wr_en && i_addr == ADDR_GLOBAL_CFG0) begin
            next_global_config_0 = i_wdata & GLOBAL_CONFIG_0_WMASK;
        end
        if (i_wr_en && i_addr == ADDR_GLOBAL_CFG1) begin
            next_global_config_1 = i_wdata & GLOBAL_CONFIG_1_WMASK;
        end
        // Indication is live, so it clears once the channel goes quiet
        next_ind = IND_RESET;
        for (int c = 0; c < NUM_CH; c++) begin
            next_ind[2*c] = pend_s2[c];
        end
        if (soft_rst) begin
            next_global_config_0 = GLOBAL_CONFIG_0_RESET;
            next_global_config_1 = GLOBAL_CONFIG_1_RESET;
            next_ind = IND_RESET;
        end
    end

    // Per-channel jitter registers, broadcast-aware
    // Broadcast uses the copy bit as it stands at the write edge, so the
    // write that turns broadcast on is itself not copied.
    // Decoded settings follow the next value, keeping outputs in step with the register.
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            always_comb begin
                next_jacfg[c] = jacfg[c];
                if (i_wr_en && hits(i_addr, ADDR_JITTER_CFG) &&
                    (global_config_0[GLOBAL_CONFIG_0_COPY_BIT] ||
                     i_addr[CH_SEL_MSB:CH_SEL_LSB] == 2'(c))) begin
                    next_jacfg[c] = i_wdata & JACFG_WMASK;
                end
                if (soft_rst) begin
                    next_jacfg[c] = JACFG_RESET;
                end
                next_jitter[c] = decode_ja(next_jacfg[c]);
            end
        end
    endgenerate

    // Interrupt pin, monitor decode and read data
    // Pin logic looks at next values so style and mask changes take effect
    // in the same cycle as the registers they come from.
    // Read data uses current register values: reads see earlier writes only.
    always_comb begin
        irq_any = (|next_ind) && !next_global_config_0[GLOBAL_CONFIG_0_MASK_BIT];
        // Open drain only sinks; push-pull drives both levels
        if (!next_global_config_0[GLOBAL_CONFIG_0_PIN_LSB]) begin
            next_irq_out = 1'b0;
            next_irq_oe = irq_any;
        end else begin
            next_irq_out = next_global_config_0[GLOBAL_CONFIG_0_PIN_MSB] ? irq_any : !irq_any;
            next_irq_oe = 1'b1;
        end
        // Reserved odd codes disable monitoring rather than guess
        next_monitor.source_ch = next_global_config_1[GLOBAL_CONFIG_1_MON_LSB+1 +: 2];
        next_monitor.rx_active = !next_global_config_1[GLOBAL_CONFIG_1_MON_LSB] && !next_global_config_1[7] &&
                                 (next_global_config_1[GLOBAL_CONFIG_1_MON_LSB+1 +: 2] != 2'h0);
        next_monitor.tx_active = !next_global_config_1[GLOBAL_CONFIG_1_MON_LSB] && next_global_config_1[7] &&
                                 (next_global_config_1[GLOBAL_CONFIG_1_MON_LSB+1 +: 2] != 2'h0);
        next_rdata = 8'h00;
        if (i_rd_en) begin
            if (hits(i_addr, ADDR_JITTER_CFG)) begin
                next_rdata = jacfg[i_addr[CH_SEL_MSB:CH_SEL_LSB]];
            end else if (i_addr == ADDR_GLOBAL_CFG0) begin
                next_rdata = global_config_0;
            end else if (i_addr == ADDR_GLOBAL_CFG1) begin
                next_rdata = global_config_1;
            end else if (i_addr == ADDR_CH_IRQ_IND) begin
                next_rdata = ind;
            end
        end
    end

    // Registering; synchronous reset mirrors soft reset values
    // Outputs reset to their idle values so the pin floats until configured.
    // Every register runs each edge; no enables are used.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            pend_s1 <= '0;
            pend_s2 <= '0;
            global_config_0 <= GLOBAL_CONFIG_0_RESET;
            global_config_1 <= GLOBAL_CONFIG_1_RESET;
            ind <= IND_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                jacfg[c] <= JACFG_RESET;
            end
            o_rdata <= 8'h00;
            o_line_standard_select <= 1'b0;
            o_irq_out <= 1'b0;
            o_irq_oe <= 1'b0;
            o_monitor <= '0;
            o_jitter <= '0;
        end else begin
            pend_s1 <= i_ch_irq_pending;
            pend_s2 <= pend_s1;
            global_config_0 <= next_global_config_0;
            global_config_1 <= next_global_config_1;
            ind <= next_ind;
            for (int c = 0; c < NUM_CH; c++) begin
                jacfg[c] <= next_jacfg[c];
            end
            o_rdata <= next_rdata;
            o_line_standard_select <= next_global_config_0[GLOBAL_CONFIG_0_STD_BIT];
            o_irq_out <= next_irq_out;
            o_irq_oe <= next_irq_oe;
            o_monitor <= next_monitor;
            o_jitter <= next_jitter;
        end
    end

endmodule : liucfg_regs

/* tb/liucfg_regs_properties.sv */
`timescale 1ns/1ps
module liucfg_regs_chk
    import liucfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [NUM_CH-1:0] i_ch_irq_pending,
    input wire logic [7:0] o_rdata,
    input wire logic o_line_standard_select,
    input wire logic o_irq_out,
    input wire logic o_irq_oe,
    input wire liucfg_mon_t o_monitor,
    input wire liucfg_ja_t [NUM_CH-1:0] o_jitter
);
    logic [2:0] gcf_low;
    logic [2:0] next_gcf_low;
    wire wr_gcf = i_wr_en && i_addr == ADDR_GLOBAL_CFG0;
    wire wr_rst = i_wr_en && i_addr == ADDR_SOFT_RESET;
    wire wr_ja = i_wr_en && i_addr[5:0] == 6'h01;
    // Pin counts as asserted by style, so one check covers all three styles
    wire irq_on = o_irq_oe && (o_irq_out == (gcf_low[1:0] == 2'h3));
    // Shadow of mask and pin style, needed to judge the pin
    always_comb begin
        next_gcf_low = gcf_low;
        if (wr_rst) begin
            next_gcf_low = 3'h4;
        end else if (wr_gcf) begin
            next_gcf_low = i_wdata[2:0];
        end
    end
    always_ff @(posedge i_clk_sys) begin
        gcf_low <= i_nrst ? next_gcf_low : 3'h4;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Stable settings for five samples, enough to cover the pending sync
    sequence s_quiet;
        (i_ch_irq_pending == 4'h0 && $stable(gcf_low))[*5];
    endsequence
    sequence s_active;
        (i_ch_irq_pending != 4'h0 && !gcf_low[2] && $stable(gcf_low))[*5];
    endsequence
    chk_std_write: assert property (wr_gcf |=> o_line_standard_select == $past(i_wdata[4]))
        else $error("line standard not taken from write");
    chk_soft_default: assert property (wr_rst |=> !o_line_standard_select && o_jitter == '0)
        else $error("soft reset left settings");
    chk_ind_layout: assert property (i_rd_en && i_addr == ADDR_CH_IRQ_IND |=> (o_rdata & 8'haa) == 8'h00)
        else $error("odd indication bit set");
    chk_ja_decode: assert property (wr_ja |=> o_jitter[$past(i_addr[7:6])] ==
        {$past(i_wdata[3]) ? {$past(i_wdata[4]), !$past(i_wdata[4])} : 2'h0,
        $past(i_wdata[2]) ? 2'h2 : {1'b0, $past(i_wdata[1])}, $past(i_wdata[5]), $past(i_wdata[0])})
        else $error("jitter decode wrong");
    chk_mon_decode: assert property (i_wr_en && i_addr == ADDR_GLOBAL_CFG1 |=>
        o_monitor.rx_active == ($past(i_wdata[7:4]) inside {4'h2, 4'h4, 4'h6}) &&
        o_monitor.tx_active == ($past(i_wdata[7:4]) inside {4'ha, 4'hc, 4'he}))
        else $error("monitor decode wrong");
    chk_mask_blocks: assert property ((gcf_low[2] && $stable(gcf_low))[*2] |-> !irq_on)
        else $error("pin asserted while masked");
    chk_irq_raise: assert property (s_active |-> irq_on)
        else $error("pin not asserted");
    chk_irq_clear: assert property (s_quiet |-> !irq_on)
        else $error("pin stuck asserted");
endmodule : liucfg_regs_chk
bind liucfg_regs liucfg_regs_chk chk_u (.*);

/* tb/tb_liucfg_regs.sv */
`timescale 1ns/1ps
module tb_liucfg_regs
    import liucfg_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [NUM_CH-1:0] i_ch_irq_pending = 4'h0;
    logic [7:0] o_rdata;
    logic o_line_standard_select;
    logic o_irq_out;
    logic o_irq_oe;
    liucfg_mon_t o_monitor;
    liucfg_ja_t [NUM_CH-1:0] o_jitter;
    int failures = 0;
    int check_count = 0;
    liucfg_regs dut_u (.*);
    always #5 i_clk_sys = ~i_clk_sys;
    task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // Strobes drop at the next falling edge, one request per rising edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {i_wr_en, i_addr, i_wdata} = {1'b1, a, d};
        @(negedge i_clk_sys);
        i_wr_en = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        {i_rd_en, i_addr} = {1'b1, a};
        @(negedge i_clk_sys);
        i_rd_en = 1'b0;
        cmp("read", e, o_rdata);
    endtask : rd
    task t_global;
        rd(ADDR_GLOBAL_CFG0, 8'h04);
        rd(ADDR_CH_IRQ_IND, 8'h00);
        rd(8'ha0, 8'h00);
        wr(ADDR_GLOBAL_CFG0, 8'hd4);
        rd(ADDR_GLOBAL_CFG0, 8'h14);
        cmp("std", 8'h01, {7'h0, o_line_standard_select});
        wr(ADDR_GLOBAL_CFG0, 8'h04);
    endtask : t_global
    task t_jitter;
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h3f);
        rd(8'hc1, 8'h00);
        cmp("ja2", 8'h2b, {2'h0, o_jitter[1]});
        wr(ADDR_GLOBAL_CFG0, 8'h0c);
        wr(8'h81, 8'h0a);
        for (int c = 0; c < 4; c++) begin
            rd({c[1:0], 6'h01}, 8'h0a);
        end
        cmp("ja1", 8'h14, {2'h0, o_jitter[0]});
        wr(ADDR_GLOBAL_CFG0, 8'h04);
    endtask : t_jitter
    task t_monitor;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_GLOBAL_CFG1, {c[3:0], 4'hf});
            rd(ADDR_GLOBAL_CFG1, {c[3:0], 4'h0});
            cmp("mon", {6'h0, c inside {2, 4, 6}, c inside {10, 12, 14}},
                {6'h0, o_monitor.rx_active, o_monitor.tx_active});
        end
    endtask : t_monitor
    // Pin sampled two cycles after a style write, output is registered
    task t_irq;
        i_ch_irq_pending = 4'h5;
        repeat (5) @(negedge i_clk_sys);
        rd(ADDR_CH_IRQ_IND, 8'h11);
        cmp("masked", 8'h00, {7'h0, o_irq_oe});
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_GLOBAL_CFG0, {6'h0, s[1:0]});
            repeat (2) @(negedge i_clk_sys);
            cmp("pin", s == 3 ? 8'h03 : 8'h02, {6'h0, o_irq_oe, o_irq_out});
        end
        i_ch_irq_pending = 4'h0;
        repeat (5) @(negedge i_clk_sys);
        // Push-pull high style keeps driving, now at the inactive low level
        cmp("idle", 8'h02, {6'h0, o_irq_oe, o_irq_out});
        rd(ADDR_CH_IRQ_IND, 8'h00);
    endtask : t_irq
    task t_soft;
        wr(8'h41, 8'h15);
        wr(ADDR_SOFT_RESET, 8'h5a);
        rd(ADDR_GLOBAL_CFG0, 8'h04);
        rd(8'h41, 8'h00);
        rd(ADDR_SOFT_RESET, 8'h00);
    endtask : t_soft
    task close_out;
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        t_global();
        t_jitter();
        t_monitor();
        t_irq();
        t_soft();
        close_out();
    end
    // Whole run is about 140 cycles
    initial begin
        #50us;
        failures++;
        close_out();
    end
endmodule : tb_liucfg_regs
